/* File: shared/scdc_pkg.sv */
// shared constants, types and decode functions of the skew clock driver control
package scdc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned MCLK_PERIOD_PS = 10000;
   localparam int unsigned TU_PER_VCO = 16;
   localparam int unsigned PS_PER_US = 1000000;
   localparam int unsigned LO_RANGE_MIN_MHZ = 50;
   localparam int unsigned LO_RANGE_MAX_MHZ = 125;
   localparam int unsigned HI_RANGE_MIN_MHZ = 100;
   localparam int unsigned HI_RANGE_MAX_MHZ = 250;
   localparam int unsigned LOCK_EDGES = 8;
   localparam int unsigned LOCK_TOL_CYC = 1;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int unsigned PER_W = 16;
   localparam int unsigned BANKS = 5;
   localparam int unsigned GENS = BANKS + 2;
   localparam logic RST_CLK = 1'b0;
   localparam logic RST_OE = 1'b0;

   // ----------------------------------------------------------------
   // three-level pin codes: 2'b11 means nothing drives the pin
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TL_LOW = 2'b00,
      TL_MID = 2'b01,
      TL_HIGH = 2'b10,
      TL_OPEN = 2'b11
   } scdc_tl_t;

   typedef enum logic [1:0] {
      OM_SKEW = 2'b00,
      OM_DIV2 = 2'b01,
      OM_DIV4 = 2'b10,
      OM_INV = 2'b11
   } scdc_stop_style_t;

   typedef enum logic [1:0] {
      LK_HUNT = 2'b00,
      LK_ACQ = 2'b01,
      LK_LOCK = 2'b11
   } scdc_lock_t;

   // level of one three-level wire, 0 low, 1 mid, 2 high; open reads mid
   function automatic logic [1:0] scdc_tl_val(input logic [1:0] code);
      logic [1:0] v;
      v = 2'h1;
      if (code == TL_LOW) begin
         v = 2'h0;
      end else if (code == TL_HIGH) begin
         v = 2'h2;
      end
      return v;
   endfunction

   // feedback divide ratio, index = hi * 3 + lo
   function automatic logic [3:0] scdc_fb_ratio(input logic [3:0] code);
      logic [3:0] idx;
      logic [3:0] r;
      idx = 4'((scdc_tl_val(code[3:2]) * 3) + scdc_tl_val(code[1:0]));
      case (idx)
         4'h0: r = 4'h2;
         4'h1: r = 4'h3;
         4'h2: r = 4'h4;
         4'h3: r = 4'h5;
         4'h4: r = 4'h1;
         4'h5: r = 4'h6;
         4'h6: r = 4'h8;
         4'h7: r = 4'ha;
         default: r = 4'hc;
      endcase
      return r;
   endfunction

endpackage

/* File: hw/scdc_skew_dec.sv */
// decodes one three-wire three-level skew selector into mode and skew steps
`timescale 1ns/10ps
`default_nettype none
module scdc_skew_dec
   import scdc_pkg::*;
(
   input wire logic [5:0] sel,
   output scdc_stop_style_t mode,
   output logic signed [3:0] skew
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [1:0] top;
   logic [3:0] low_idx;

   // low two wires form an index 0..8, top wire picks the half
   always_comb begin
      top = scdc_tl_val(sel[5:4]);
      low_idx = 4'((scdc_tl_val(sel[3:2]) * 3) + scdc_tl_val(sel[1:0]));
      mode = OM_SKEW;
      skew = 4'sh0;
      if (top == 2'h0) begin
         if (low_idx == 4'h0) begin
            mode = OM_DIV2;
         end else if (low_idx != 4'h8) begin
            skew = 4'(4'h8 - low_idx);
         end
      end else if (top == 2'h2) begin
         if (low_idx == 4'h0) begin
            mode = OM_INV;
         end else if (low_idx == 4'h8) begin
            mode = OM_DIV4;
         end else begin
            skew = 4'(4'h0 - low_idx);
         end
      end
      // mid on the top wire has no entry: treated as zero skew
   end

endmodule
`default_nettype wire

/* File: hw/scdc_out_gen.sv */
// one output clock: waveform from vco phase, synchronous stop, power-down levels
`timescale 1ns/10ps
`default_nettype none
module scdc_out_gen
   import scdc_pkg::*;
#(
   parameter bit INVERT_OUT = 1'b0
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] phase,
   input wire logic [1:0] vdiv,
   input wire logic ref_lvl,
   input wire logic bypass,
   input wire logic power_down_n,
   input wire logic polarity,
   input wire logic stop_req,
   input wire logic style,
   input wire scdc_stop_style_t mode,
   input wire logic signed [3:0] skew,
   output logic clk_out,
   output logic oe_out
);

   // ----------------------------------------------------------------
   // waveform and stop state
   // ----------------------------------------------------------------
   logic raw;
   logic [3:0] shifted;
   logic stop_lvl;
   logic boundary;
   logic raw_q, raw_d;
   logic stopped_q, stopped_d;
   logic clk_q, clk_d;
   logic oe_q, oe_d;

   always_comb begin
      shifted = 4'(phase - skew);
      // high half of the vco period, rising edge at phase zero
      case (mode)
         OM_DIV2: raw = ~vdiv[0];
         OM_DIV4: raw = ~vdiv[1];
         OM_INV: raw = phase[3];
         default: raw = ~shifted[3];
      endcase
      // bypass passes the reference straight through
      if (bypass) begin
         raw = ref_lvl;
      end
      if (INVERT_OUT) begin
         raw = ~raw;
      end
      // gated level opposite to polarity, complement takes polarity
      stop_lvl = INVERT_OUT ? polarity : ~polarity;
      // change stop state only on an edge into the stop level
      boundary = (raw != raw_q) && (raw == stop_lvl);
      raw_d = power_down_n ? raw : raw_q;
      stopped_d = boundary ? stop_req : stopped_q;
      // power-down freezes waveform, and picks the stop form
      if (!power_down_n) begin
         clk_d = stop_lvl;
         oe_d = style;
      end else if (stopped_d) begin
         // halted bank, tri-state when style is low
         clk_d = stop_lvl;
         oe_d = style;
      end else begin
         clk_d = raw;
         oe_d = 1'b1;
      end
   end

   // registers only
   always_ff @(posedge mclk) begin
      if (rst) begin
         raw_q <= RST_CLK;
         stopped_q <= 1'b0;
         clk_q <= RST_CLK;
         oe_q <= RST_OE;
      end else begin
         raw_q <= raw_d;
         stopped_q <= stopped_d;
         clk_q <= clk_d;
         oe_q <= oe_d;
      end
   end

   assign clk_out = clk_q;
   assign oe_out = oe_q;

endmodule
`default_nettype wire

/* File: hw/scdc_top.sv */
// top of the skew clock driver control: reference choice, lock, vco model, outputs
`timescale 1ns/10ps
`default_nettype none

// Contract
// - ref_sel low picks ref_in_a, high picks ref_in_b.
// - a bank whose stop input is high halts both outputs synchronously.
// - gated stop holds outputs opposite to the edge polarity level.
// - with stop style low a stopped bank is tri-stated.
// - outputs align to rising reference edge when polarity high, else falling.
// - each bank and the feedback have a three-wire three-level selector.
// - bypass high disables the pll and passes the reference to every output.
// - power_down_n low disables inputs and stops all internal switching.
// - with stop style high, power-down gates banks and true feedback opposite, complement at polarity.
// - lock high when locked, low when outputs may not follow the reference.
// - vco_range_sel picks one of two oscillator ranges.
// - a two-wire three-level selector sets the feedback divide ratio.
// - five banks of two outputs plus true and complement feedback.
// - feedback divider codes map to 2,3,4,5,1,6,8,10,12.
// - skew step is a sixteenth of vco period; two vco frequency bands.
// - an undriven three-level pin reads as mid.
module scdc_top
   import scdc_pkg::*;
#(
   parameter int unsigned RANGE_SCALE = 16,
   parameter int unsigned LOCK_COUNT = LOCK_EDGES
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ref_in_a,
   input wire logic ref_in_b,
   input wire logic ref_sel,
   input wire logic [BANKS-1:0] bank_stop_n,
   input wire logic stop_style,
   input wire logic edge_polarity_sel,
   input wire logic [BANKS-1:0][5:0] bank_skew_sel,
   input wire logic [5:0] feedback_skew_sel,
   input wire logic vco_range_sel,
   input wire logic [3:0] fb_divider_sel,
   input wire logic power_down_n,
   input wire logic pll_bypass,
   output logic lock_out,
   output logic [2*BANKS-1:0] bank_clk_out,
   output logic [2*BANKS-1:0] bank_clk_oe,
   output logic feedback_clk_out,
   output logic feedback_clk_oe,
   output logic feedback_clk_out_n,
   output logic feedback_clk_oe_n
);

   // ----------------------------------------------------------------
   // vco period bounds in mclk cycles
   // ----------------------------------------------------------------
   // the model runs the vco RANGE_SCALE times slower than the real part,
   // since sixteen skew steps per vco period must fit in mclk cycles
   localparam int unsigned LO_MIN_CYC =
      (PS_PER_US * RANGE_SCALE + LO_RANGE_MAX_MHZ * MCLK_PERIOD_PS - 1) /
      (LO_RANGE_MAX_MHZ * MCLK_PERIOD_PS);
   localparam int unsigned LO_MAX_CYC =
      (PS_PER_US * RANGE_SCALE) / (LO_RANGE_MIN_MHZ * MCLK_PERIOD_PS);
   localparam int unsigned HI_MIN_CYC =
      (PS_PER_US * RANGE_SCALE + HI_RANGE_MAX_MHZ * MCLK_PERIOD_PS - 1) /
      (HI_RANGE_MAX_MHZ * MCLK_PERIOD_PS);
   localparam int unsigned HI_MAX_CYC =
      (PS_PER_US * RANGE_SCALE) / (HI_RANGE_MIN_MHZ * MCLK_PERIOD_PS);
   localparam logic [PER_W-1:0] PER_MAX = '1;

   // ----------------------------------------------------------------
   // reference selection and edge detection
   // ----------------------------------------------------------------
   logic ref_lvl_q, ref_lvl_d;
   logic ref_sel_q, ref_sel_d;
   logic ref_edge;
   logic sel_change;

   always_comb begin
      ref_lvl_d = ref_sel ? ref_in_b : ref_in_a;
      ref_sel_d = ref_sel;
      // inputs disabled in power-down: hold the last level
      if (!power_down_n) begin
         ref_lvl_d = ref_lvl_q;
         ref_sel_d = ref_sel_q;
      end
      // align on rising edge when polarity high, falling when low
      if (edge_polarity_sel) begin
         ref_edge = ref_lvl_d & ~ref_lvl_q;
      end else begin
         ref_edge = ~ref_lvl_d & ref_lvl_q;
      end
      sel_change = ref_sel_d != ref_sel_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_lvl_q <= 1'b0;
         ref_sel_q <= 1'b0;
      end else begin
         ref_lvl_q <= ref_lvl_d;
         ref_sel_q <= ref_sel_d;
      end
   end

   // ----------------------------------------------------------------
   // reference period measurement and lock
   // ----------------------------------------------------------------
   logic [PER_W-1:0] pcnt_q, pcnt_d;
   logic [PER_W-1:0] per_q, per_d;
   logic [PER_W-1:0] new_per;
   logic [PER_W-1:0] per_lo, per_hi;
   logic [PER_W-1:0] per_diff;
   logic [3:0] ratio;
   logic [7:0] match_q, match_d;
   logic period_ok;
   scdc_lock_t lk_q, lk_d;
   logic lock_q, lock_d;

   always_comb begin
      // feedback divider ratio from its selector
      ratio = scdc_fb_ratio(fb_divider_sel);
      new_per = (pcnt_q == PER_MAX) ? PER_MAX : PER_W'(pcnt_q + 1'b1);
      // vco period P/ratio must sit inside the chosen band
      if (vco_range_sel) begin
         per_lo = PER_W'(ratio * HI_MIN_CYC);
         per_hi = PER_W'(ratio * HI_MAX_CYC);
      end else begin
         per_lo = PER_W'(ratio * LO_MIN_CYC);
         per_hi = PER_W'(ratio * LO_MAX_CYC);
      end
      per_diff = (new_per > per_q) ? PER_W'(new_per - per_q) : PER_W'(per_q - new_per);
      period_ok = (new_per >= per_lo) && (new_per <= per_hi) &&
                  (per_diff <= PER_W'(LOCK_TOL_CYC));
      pcnt_d = ref_edge ? '0 : new_per;
      per_d = ref_edge ? new_per : per_q;
      match_d = match_q;
      lk_d = lk_q;
      case (lk_q)
         LK_HUNT: begin
            match_d = 8'h0;
            if (ref_edge && period_ok) begin
               lk_d = LK_ACQ;
            end
         end
         LK_ACQ: begin
            if (ref_edge) begin
               if (!period_ok) begin
                  lk_d = LK_HUNT;
               end else if (match_d == 8'(LOCK_COUNT - 1)) begin
                  lk_d = LK_LOCK;
               end else begin
                  match_d = 8'(match_q + 1'b1);
               end
            end
         end
         default: begin
            if (ref_edge && !period_ok) begin
               lk_d = LK_HUNT;
            end
         end
      endcase
      // a reference that stops drops lock once the count passes per_hi
      if (new_per > per_hi && lk_q == LK_LOCK) begin
         lk_d = LK_HUNT;
      end
      // reference switch is a disturbance, bypass disables pll
      if (sel_change || pll_bypass || !power_down_n) begin
         lk_d = LK_HUNT;
      end
      if (!power_down_n) begin
         pcnt_d = pcnt_q;
         per_d = per_q;
      end
      // lock indicator follows the locked state
      lock_d = lk_d == LK_LOCK;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pcnt_q <= '0;
         per_q <= '0;
         match_q <= 8'h0;
         lk_q <= LK_HUNT;
         lock_q <= 1'b0;
      end else begin
         pcnt_q <= pcnt_d;
         per_q <= per_d;
         match_q <= match_d;
         lk_q <= lk_d;
         lock_q <= lock_d;
      end
   end

   // ----------------------------------------------------------------
   // vco model: skew steps from an accumulator
   // ----------------------------------------------------------------
   // each cycle adds 16*ratio; a wrap past the reference period is one
   // skew step, so sixteen steps make one vco period of P/ratio cycles
   logic [PER_W:0] acc_q, acc_d;
   logic [PER_W:0] acc_sum;
   logic [3:0] phase_q, phase_d;
   logic [1:0] vdiv_q, vdiv_d;
   logic step;

   always_comb begin
      acc_sum = (PER_W + 1)'(acc_q + {ratio, 4'h0});
      // one step is a sixteenth of the vco period
      step = (per_q != '0) && (acc_sum >= {1'b0, per_q});
      acc_d = step ? (PER_W + 1)'(acc_sum - {1'b0, per_q}) : acc_sum;
      phase_d = step ? 4'(phase_q + 1'b1) : phase_q;
      vdiv_d = (step && phase_q == 4'hf) ? 2'(vdiv_q + 1'b1) : vdiv_q;
      // phase zero is pinned to the selected reference edge
      if (ref_edge) begin
         acc_d = '0;
         phase_d = 4'h0;
      end
      if (!power_down_n) begin
         acc_d = acc_q;
         phase_d = phase_q;
         vdiv_d = vdiv_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_q <= '0;
         phase_q <= 4'h0;
         vdiv_q <= 2'h0;
      end else begin
         acc_q <= acc_d;
         phase_q <= phase_d;
         vdiv_q <= vdiv_d;
      end
   end

   // ----------------------------------------------------------------
   // output generators: five banks, true feedback, complement feedback
   // ----------------------------------------------------------------
   logic [GENS-1:0] gen_clk;
   logic [GENS-1:0] gen_oe;

   // one selector and generator per bank and for feedback
   for (genvar g = 0; g < GENS; g++) begin : gen_out
      scdc_stop_style_t mode;
      logic signed [3:0] skew;

      // open selector pins decode as mid inside the decoder
      scdc_skew_dec u_dec (
         .sel(g < BANKS ? bank_skew_sel[g % BANKS] : feedback_skew_sel),
         .mode(mode),
         .skew(skew)
      );

      // complement feedback instance stops at the polarity level
      scdc_out_gen #(
         .INVERT_OUT(g == GENS - 1)
      ) u_gen (
         .mclk(mclk),
         .rst(rst),
         .phase(phase_q),
         .vdiv(vdiv_q),
         .ref_lvl(ref_lvl_q),
         .bypass(pll_bypass),
         .power_down_n(power_down_n),
         .polarity(edge_polarity_sel),
         .stop_req(g < BANKS ? bank_stop_n[g % BANKS] : 1'b0),
         .style(stop_style),
         .mode(mode),
         .skew(skew),
         .clk_out(gen_clk[g]),
         .oe_out(gen_oe[g])
      );
   end

   // both pins of a bank share one flip-flop
   for (genvar b = 0; b < BANKS; b++) begin : gen_pins
      assign bank_clk_out[2*b+1:2*b] = {2{gen_clk[b]}};
      assign bank_clk_oe[2*b+1:2*b] = {2{gen_oe[b]}};
   end

   assign feedback_clk_out = gen_clk[BANKS];
   assign feedback_clk_oe = gen_oe[BANKS];
   assign feedback_clk_out_n = gen_clk[BANKS+1];
   assign feedback_clk_oe_n = gen_oe[BANKS+1];
   assign lock_out = lock_q;

endmodule
`default_nettype wire

/* File: tb/scdc_ref_src.sv */
// board reference source: two square waves with settable half periods
`timescale 1ns/10ps
`default_nettype none
module scdc_ref_src (
   input wire logic mclk,
   input wire logic run,
   input wire logic [7:0] half_a,
   input wire logic [7:0] half_b,
   output logic ref_in_a,
   output logic ref_in_b
);
   logic [7:0] cnt_a = 8'h00;
   logic [7:0] cnt_b = 8'h00;
   // ----------------------------------------------------------------
   // waves
   // ----------------------------------------------------------------
   initial begin
      ref_in_a = 1'b0;
      ref_in_b = 1'b0;
   end
   // moves on the falling edge so the sampling edge never races it;
   // a halted source holds its level like a stopped oscillator
   always @(negedge mclk) begin
      if (run) begin
         cnt_a <= (cnt_a + 8'h01 >= half_a) ? 8'h00 : cnt_a + 8'h01;
         cnt_b <= (cnt_b + 8'h01 >= half_b) ? 8'h00 : cnt_b + 8'h01;
         if (cnt_a + 8'h01 >= half_a) begin
            ref_in_a <= ~ref_in_a;
         end
         if (cnt_b + 8'h01 >= half_b) begin
            ref_in_b <= ~ref_in_b;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/scdc_top_properties.sv */
// concurrent checks on the skew clock driver control ports
`timescale 1ns/10ps
`default_nettype none
module scdc_chk
   import scdc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ref_in_a,
   input wire logic ref_in_b,
   input wire logic ref_sel,
   input wire logic [BANKS-1:0] bank_stop_n,
   input wire logic stop_style,
   input wire logic edge_polarity_sel,
   input wire logic [BANKS-1:0][5:0] bank_skew_sel,
   input wire logic [5:0] feedback_skew_sel,
   input wire logic vco_range_sel,
   input wire logic [3:0] fb_divider_sel,
   input wire logic power_down_n,
   input wire logic pll_bypass,
   input wire logic lock_out,
   input wire logic [2*BANKS-1:0] bank_clk_out,
   input wire logic [2*BANKS-1:0] bank_clk_oe,
   input wire logic feedback_clk_out,
   input wire logic feedback_clk_oe,
   input wire logic feedback_clk_out_n,
   input wire logic feedback_clk_oe_n
);
   localparam int STOP_WAIT = 64;
   logic [45:0] cfg, cfg_q;
   logic [7:0] calm_q, calm_d, stop_q, stop_d;
   logic [1:0] live_q, live_d;
   logic sel_ref, pol, live;
   // ----------------------------------------------------------------
   // settle counters
   // ----------------------------------------------------------------
   assign pol = edge_polarity_sel;
   assign sel_ref = ref_sel ? ref_in_b : ref_in_a;
   assign live = (live_q == 2'h3);
   assign cfg = {ref_sel, stop_style, pol, power_down_n, pll_bypass, vco_range_sel,
      fb_divider_sel, feedback_skew_sel, bank_skew_sel};
   // outputs trail a setting change: wait for quiet inputs
   always_comb begin
      live_d = live ? live_q : live_q + 2'h1;
      calm_d = (cfg != cfg_q) ? 8'h00 : calm_q + {7'h00, calm_q != 8'hff};
      stop_d = 8'h00;
      if (cfg == cfg_q && bank_stop_n[0] && pll_bypass && power_down_n) begin
         stop_d = stop_q + {7'h00, stop_q != 8'hff};
      end
   end
   always_ff @(posedge mclk) begin
      cfg_q <= cfg;
      if (rst) begin
         live_q <= 2'h0;
         calm_q <= 8'h00;
         stop_q <= 8'h00;
      end else begin
         live_q <= live_d;
         calm_q <= calm_d;
         stop_q <= stop_d;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_full_rise;
      live && calm_q > 8'h3f && $rose(bank_clk_out[0]) && bank_clk_oe[0];
   endsequence
   sequence s_stopped;
      live && stop_q >= STOP_WAIT;
   endsequence
   a_pd_gated_level: assert property (
      live && !power_down_n && stop_style |=> bank_clk_oe == '1 && feedback_clk_oe
      && feedback_clk_oe_n && bank_clk_out == {2*BANKS{~$past(pol)}}
      && feedback_clk_out == ~$past(pol) && feedback_clk_out_n == $past(pol))
      else $error("gated power-down levels wrong");
   a_pd_tristate: assert property (
      live && !power_down_n && !stop_style |=> bank_clk_oe == '0 && !feedback_clk_oe
      && !feedback_clk_oe_n)
      else $error("power-down outputs still driven");
   a_pd_no_lock: assert property (live && !power_down_n |=> !lock_out)
      else $error("lock high in power-down");
   a_bypass_follow: assert property (
      live && pll_bypass && power_down_n && pol && calm_q > 8'h03 && !bank_stop_n[4]
      |-> bank_clk_oe[8] && bank_clk_out[8] == $past(sel_ref, 2))
      else $error("bypass output does not follow reference");
   a_bypass_no_lock: assert property (live && pll_bypass |-> ##[1:2] !lock_out)
      else $error("lock high in bypass");
   a_sel_drops_lock: assert property (live && $changed(ref_sel) |-> ##[1:2] !lock_out)
      else $error("lock kept over reference change");
   a_stop_gated: assert property (
      s_stopped and stop_style |-> bank_clk_oe[1:0] == 2'h3 && bank_clk_out[1:0] == {2{~pol}})
      else $error("stopped bank not at gated level");
   a_stop_tristate: assert property (
      s_stopped and !stop_style |-> bank_clk_oe[1:0] == 2'h0)
      else $error("stopped bank still driven");
   a_pair_same: assert property (
      live |-> bank_clk_out[1] == bank_clk_out[0] && bank_clk_out[9] == bank_clk_out[8]
      && bank_clk_oe[1] == bank_clk_oe[0])
      else $error("outputs of a bank differ");
   a_no_runt_pulse: assert property (s_full_rise |=> bank_clk_out[0] [*2])
      else $error("shortened pulse on bank output");
endmodule
bind scdc_top scdc_chk u_chk (.mclk(mclk), .rst(rst), .ref_in_a(ref_in_a),
   .ref_in_b(ref_in_b), .ref_sel(ref_sel), .bank_stop_n(bank_stop_n),
   .stop_style(stop_style), .edge_polarity_sel(edge_polarity_sel),
   .bank_skew_sel(bank_skew_sel), .feedback_skew_sel(feedback_skew_sel),
   .vco_range_sel(vco_range_sel), .fb_divider_sel(fb_divider_sel),
   .power_down_n(power_down_n), .pll_bypass(pll_bypass), .lock_out(lock_out),
   .bank_clk_out(bank_clk_out), .bank_clk_oe(bank_clk_oe),
   .feedback_clk_out(feedback_clk_out), .feedback_clk_oe(feedback_clk_oe),
   .feedback_clk_out_n(feedback_clk_out_n), .feedback_clk_oe_n(feedback_clk_oe_n));
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the skew clock driver control
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import scdc_pkg::*;
;
   logic mclk, rst, ref_sel, stop_style, pol, vco, pd, byp, run;
   logic ref_in_a, ref_in_b, lock_out, fb_out, fb_oe, fb_out_n, fb_oe_n;
   logic [BANKS-1:0] stop_n;
   logic [BANKS-1:0][5:0] bsel;
   logic [5:0] fsel;
   logic [3:0] fdiv;
   logic [7:0] half_a, half_b;
   logic [2*BANKS-1:0] bout, boe;
   logic [6:0] w;
   logic [6:0] w_q = 7'h00;
   int errors = 0;
   int checks = 0;
   int cyc_n = 0;
   int d;
   int rise_t[7] = '{default: 0};
   int rise_n[7] = '{default: 0};
   int n0[7];
   logic [3:0] dcode[10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hf};
   int dratio[10] = '{2, 3, 4, 5, 1, 6, 8, 10, 12, 1};
   scdc_ref_src src (.mclk(mclk), .run(run), .half_a(half_a), .half_b(half_b),
      .ref_in_a(ref_in_a), .ref_in_b(ref_in_b));
   scdc_top #(.LOCK_COUNT(2)) dut (.mclk(mclk), .rst(rst), .ref_in_a(ref_in_a),
      .ref_in_b(ref_in_b), .ref_sel(ref_sel), .bank_stop_n(stop_n), .stop_style(stop_style),
      .edge_polarity_sel(pol), .bank_skew_sel(bsel), .feedback_skew_sel(fsel),
      .vco_range_sel(vco), .fb_divider_sel(fdiv), .power_down_n(pd), .pll_bypass(byp),
      .lock_out(lock_out), .bank_clk_out(bout), .bank_clk_oe(boe), .feedback_clk_out(fb_out),
      .feedback_clk_oe(fb_oe), .feedback_clk_out_n(fb_out_n), .feedback_clk_oe_n(fb_oe_n));
   // ----------------------------------------------------------------
   // rise recorder: reference, banks 0..4, true feedback
   // ----------------------------------------------------------------
   assign w = {fb_out, bout[8], bout[6], bout[4], bout[2], bout[0], ref_in_a};
   always @(posedge mclk) begin
      cyc_n <= cyc_n + 1;
      w_q <= w;
      for (int i = 0; i < 7; i++) begin
         if (w[i] && !w_q[i]) begin
            rise_t[i] <= cyc_n;
            rise_n[i] <= rise_n[i] + 1;
         end
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // one cycle of sampling slack
   task automatic chkn(input string nm, input int exp, input int got);
      checks++;
      if (got > exp + 1 || got < exp - 1) begin
         errors++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   function automatic int m32(input int x);
      return ((x % 32) + 32) % 32;
   endfunction
   task automatic final_report();
      if (errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_lock(input int lim);
      int i;
      for (i = 0; i < lim && lock_out !== 1'b1; i++) begin
         @(negedge mclk);
      end
      checks++;
      if (i == lim) begin
         errors++;
         $display("mismatch lock_out expected 1 seen %b", lock_out);
         final_report();
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      int r;
      {rst, pd, run, pol, stop_style} = 5'h1f;
      {ref_sel, vco, byp} = 3'h0;
      stop_n = 5'h00;
      bsel = {6'h01, 6'h20, 6'h2a, 6'h00, 6'h0a};
      fsel = 6'h29;
      fdiv = 4'h5;
      half_a = 8'h10;
      half_b = 8'h10;
      cyc(12);
      rst = 1'b0;
      wait_lock(400);
      cyc(128);
      n0 = rise_n;
      cyc(512);
      chkn("zero skew rises", 16, rise_n[1] - n0[1]);
      chkn("div2 rises", 8, rise_n[2] - n0[2]);
      chkn("div4 rises", 4, rise_n[3] - n0[3]);
      chkn("inverted lag", 16, m32(rise_t[1] - rise_t[4]));
      chkn("plus7 lag", 18, m32(rise_t[1] - rise_t[5]));
      chkn("feedback minus7 lead", 14, m32(rise_t[1] - rise_t[6]));
      d = m32(rise_t[1] - rise_t[0]);
      pol = 1'b0;
      cyc(300);
      chkn("falling edge shift", 16, m32(rise_t[1] - rise_t[0] - d));
      pol = 1'b1;
      ref_sel = 1'b1;
      cyc(3);
      chk("lock_out", 0, lock_out);
      wait_lock(400);
      vco = 1'b1;
      half_a = 8'h0a;
      ref_sel = 1'b0;
      cyc(200);
      chk("lock_out", 0, lock_out);
      half_a = 8'h08;
      wait_lock(300);
      vco = 1'b0;
      run = 1'b0;
      cyc(80);
      chk("lock_out", 0, lock_out);
      run = 1'b1;
      for (int k = 0; k < 10; k++) begin
         r = dratio[k];
         fdiv = dcode[k];
         half_a = 8'(r * 10);
         wait_lock(200 * r);
         half_a = 8'(r * 20);
         cyc(100 * r);
         chk("lock_out", 0, lock_out);
      end
      for (int i = 0; i < 4; i++) begin
         {stop_style, pol} = 2'(i);
         pd = 1'b0;
         cyc(3);
         chk("bank_clk_oe", {10{stop_style}}, boe);
         chk("feedback oe", {2{stop_style}}, {fb_oe, fb_oe_n});
         if (stop_style) chk("pd levels", {{11{~pol}}, pol}, {bout, fb_out, fb_out_n});
         chk("lock_out", 0, lock_out);
         pd = 1'b1;
         cyc(3);
      end
      byp = 1'b1;
      half_a = 8'h0a;
      half_b = 8'h07;
      cyc(4);
      chk("lock_out", 0, lock_out);
      for (int s = 0; s < 2; s++) begin
         ref_sel = s[0];
         cyc(20);
         n0 = rise_n;
         cyc(280);
         chkn("bypass rises", s ? 20 : 14, rise_n[5] - n0[5]);
      end
      ref_sel = 1'b0;
      for (int i = 0; i < 3; i++) begin
         stop_style = (i != 2);
         pol = (i != 1);
         stop_n = 5'h01;
         cyc(60);
         n0 = rise_n;
         cyc(40);
         chk("stopped oe", {2{stop_style}}, boe[1:0]);
         if (stop_style) chk("stopped level", {2{~pol}}, bout[1:0]);
         chk("bank0 halted", 0, rise_n[1] - n0[1]);
         chkn("bank4 running", 2, rise_n[5] - n0[5]);
         stop_n = 5'h00;
         n0 = rise_n;
         cyc(60);
         chkn("bank0 resumed", 3, rise_n[1] - n0[1]);
      end
      final_report();
   end
endmodule
`default_nettype wire
